// ### core/pisc_pkg.sv
// Shared constants and types for the port input sampling front end
package pisc_pkg;

  localparam int NUM_PORTS = 4;
  localparam int PORT_W = 16;
  localparam int NUM_PAIRS = 2;

  typedef enum logic {
    PISC_SRC_INT = 1'b0,
    PISC_SRC_EXT = 1'b1
  } pisc_src_t;

  localparam logic [NUM_PORTS-1:0] SRC_RESET = {NUM_PORTS{PISC_SRC_INT}};

  // Settings-conflict code, two's complement of -221
  localparam logic [15:0] ERR_SETTINGS_CONFLICT = 16'hff23;
  localparam logic [15:0] ERR_NONE = 16'h0000;

  localparam int CLK_PERIOD_NS = 25;
  localparam int DEB_TIME_NS = 18000;
  localparam int DEB_BASE_CYC = (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRE_W = 10;
  localparam logic [PRE_W-1:0] DEB_TICK_LAST = PRE_W'(DEB_BASE_CYC - 1);

  localparam int DEB_CODE_W = 5;
  localparam int DEB_CNT_W = 30;
  localparam logic [DEB_CODE_W-1:0] DEB_CODE_RESET = 5'h00;
  localparam logic [DEB_CODE_W-1:0] DEB_CODE_MAX = 5'h1d;

endpackage : pisc_pkg

// ### core/pisc_ext_cap.sv
// External-clock capture stage for one port
`timescale 1ns/100ps
module pisc_ext_cap
  import pisc_pkg::*;
(
  input wire logic link_clk,
  input wire logic resetn,
  input wire logic [PORT_W-1:0] din,
  output logic [PORT_W-1:0] cap_data_q,
  output logic cap_tgl_q
);

  logic [PORT_W-1:0] cap_data_d;
  logic cap_tgl_d;

  // One load and one toggle per external pulse
  always_comb begin
    cap_data_d = din;
    cap_tgl_d = ~cap_tgl_q;
  end

  always_ff @(negedge link_clk or negedge resetn) begin
    if (!resetn) begin
      cap_data_q <= '0;
      cap_tgl_q <= 1'b0;
    end else begin
      cap_data_q <= cap_data_d;
      cap_tgl_q <= cap_tgl_d;
    end
  end

  a_ext_capture: assert property (@(negedge link_clk) disable iff (!resetn)
    1'b1 |=> (cap_data_q == $past(din)) && (cap_tgl_q != $past(cap_tgl_q)))
    else $error("external capture missed the falling edge");

endmodule : pisc_ext_cap

// ### core/pisc_top.sv
// Per-port sample source select, debounce and current value logic
`timescale 1ns/100ps
module pisc_top
  import pisc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [NUM_PORTS-1:0] link_clk,
  input wire logic [NUM_PORTS*PORT_W-1:0] in_data,
  input wire logic cfg_wr,
  input wire logic [1:0] cfg_port,
  input wire logic cfg_ext,
  input wire logic [NUM_PORTS-1:0] new_data_event_en,
  input wire logic rst_cmd,
  input wire logic deb_wr,
  input wire logic [1:0] deb_port,
  input wire logic [DEB_CODE_W-1:0] deb_code,
  output logic [NUM_PORTS-1:0] src_sel,
  output logic err_pulse,
  output logic [15:0] err_code,
  output logic [NUM_PAIRS-1:0][DEB_CODE_W-1:0] deb_code_rd,
  output logic [NUM_PORTS*PORT_W-1:0] cur_val,
  output logic [NUM_PORTS-1:0] new_data_event
);

  function automatic logic [DEB_CNT_W-1:0] deb_limit(input logic [DEB_CODE_W-1:0] code);
    return DEB_CNT_W'(1) << code;
  endfunction : deb_limit

  // Configuration state
  logic [NUM_PORTS-1:0] src_q, src_d;
  logic err_q, err_d;
  logic [15:0] err_code_q, err_code_d;
  logic [NUM_PAIRS-1:0][DEB_CODE_W-1:0] deb_q, deb_d;

  always_comb begin
    src_d = src_q;
    err_d = 1'b0;
    err_code_d = err_code_q;
    deb_d = deb_q;
    if (rst_cmd) begin
      src_d = SRC_RESET;
      deb_d = {NUM_PAIRS{DEB_CODE_RESET}};
    end else begin
      if (cfg_wr) begin
        if (cfg_ext == PISC_SRC_INT && new_data_event_en[cfg_port]) begin
          err_d = 1'b1;
          err_code_d = ERR_SETTINGS_CONFLICT;
        end else begin
          src_d[cfg_port] = cfg_ext;
        end
      end
      if (deb_wr) begin
        // Writing either port of a pair sets both
        deb_d[deb_port[1]] = (deb_code > DEB_CODE_MAX) ? DEB_CODE_MAX : deb_code;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      src_q <= SRC_RESET;
      err_q <= 1'b0;
      err_code_q <= ERR_NONE;
      deb_q <= {NUM_PAIRS{DEB_CODE_RESET}};
    end else begin
      src_q <= src_d;
      err_q <= err_d;
      err_code_q <= err_code_d;
      deb_q <= deb_d;
    end
  end

  // External capture, one per port on its own clock
  logic [NUM_PORTS-1:0][PORT_W-1:0] cap_data;
  logic [NUM_PORTS-1:0] cap_tgl;

  for (genvar g = 0; g < NUM_PORTS; g++) begin : g_cap
    pisc_ext_cap u_cap (
      .link_clk(link_clk[g]),
      .resetn(resetn),
      .din(in_data[g*PORT_W +: PORT_W]),
      .cap_data_q(cap_data[g]),
      .cap_tgl_q(cap_tgl[g])
    );
  end

  // Sampling state
  logic [NUM_PORTS-1:0][PORT_W-1:0] din_s1_q, din_s1_d, din_s2_q, din_s2_d;
  logic [NUM_PORTS-1:0] tgl_s1_q, tgl_s1_d, tgl_s2_q, tgl_s2_d, tgl_s3_q, tgl_s3_d;
  logic [NUM_PORTS-1:0] ext_edge;
  logic [NUM_PORTS-1:0][PORT_W-1:0] samp_q, samp_d;

  // Captured word is read only after its toggle has crossed; pulses must be
  // spaced by a few internal clocks or a word can be read mid-change.
  always_comb begin
    din_s1_d = in_data;
    din_s2_d = din_s1_q;
    tgl_s1_d = cap_tgl;
    tgl_s2_d = tgl_s1_q;
    tgl_s3_d = tgl_s2_q;
    ext_edge = tgl_s2_q ^ tgl_s3_q;
    samp_d = samp_q;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (src_q[p] == PISC_SRC_EXT) begin
        if (ext_edge[p]) begin
          samp_d[p] = cap_data[p];
        end
      end else begin
        samp_d[p] = din_s2_q[p];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      din_s1_q <= '0;
      din_s2_q <= '0;
      tgl_s1_q <= '0;
      tgl_s2_q <= '0;
      tgl_s3_q <= '0;
      samp_q <= '0;
    end else begin
      din_s1_q <= din_s1_d;
      din_s2_q <= din_s2_d;
      tgl_s1_q <= tgl_s1_d;
      tgl_s2_q <= tgl_s2_d;
      tgl_s3_q <= tgl_s3_d;
      samp_q <= samp_d;
    end
  end

  // Debounce state, internal clock only
  logic [NUM_PAIRS-1:0][PRE_W-1:0] pre_q, pre_d;
  logic [NUM_PAIRS-1:0] tick;
  logic [NUM_PORTS-1:0][PORT_W-1:0] last_q, last_d, cur_q, cur_d;
  logic [NUM_PORTS-1:0][DEB_CNT_W-1:0] cnt_q, cnt_d;
  logic [NUM_PORTS-1:0] evt_q, evt_d;

  always_comb begin
    logic [DEB_CNT_W-1:0] lim;
    lim = '0;
    for (int r = 0; r < NUM_PAIRS; r++) begin
      tick[r] = (pre_q[r] == DEB_TICK_LAST);
      pre_d[r] = tick[r] ? '0 : PRE_W'(pre_q[r] + PRE_W'(1));
    end
    last_d = samp_q;
    cnt_d = cnt_q;
    cur_d = cur_q;
    evt_d = '0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      lim = deb_limit(deb_q[p >> 1]);
      if (samp_q[p] != last_q[p]) begin
        cnt_d[p] = '0;
      end else if (tick[p >> 1] && cnt_q[p] != lim) begin
        cnt_d[p] = DEB_CNT_W'(cnt_q[p] + DEB_CNT_W'(1));
        if (cnt_q[p] == DEB_CNT_W'(lim - DEB_CNT_W'(1))) begin
          cur_d[p] = last_q[p];
          evt_d[p] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_q <= '0;
      last_q <= '0;
      cnt_q <= '0;
      cur_q <= '0;
      evt_q <= '0;
    end else begin
      pre_q <= pre_d;
      last_q <= last_d;
      cnt_q <= cnt_d;
      cur_q <= cur_d;
      evt_q <= evt_d;
    end
  end

  assign src_sel = src_q;
  assign err_pulse = err_q;
  assign err_code = err_code_q;
  assign deb_code_rd = deb_q;
  assign cur_val = cur_q;
  assign new_data_event = evt_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_reset_cmd_int: assert property (rst_cmd |=> src_sel == SRC_RESET)
    else $error("reset command left a port on the external source");

  a_conflict_reject: assert property (
    cfg_wr && !rst_cmd && cfg_ext == PISC_SRC_INT && new_data_event_en[cfg_port]
    |=> err_pulse && $stable(src_sel))
    else $error("conflicting internal select was not refused");

  a_conflict_code: assert property (err_pulse |-> err_code == ERR_SETTINGS_CONFLICT)
    else $error("error pulse without settings-conflict code");

  a_ext_select: assert property (
    cfg_wr && !rst_cmd && cfg_ext == PISC_SRC_EXT
    |=> src_sel[$past(cfg_port)] == PISC_SRC_EXT && !err_pulse)
    else $error("external select not taken");

  a_int_sample: assert property (
    src_q[0] == PISC_SRC_INT |=> samp_q[0] == $past(din_s2_q[0]))
    else $error("internal source did not sample every clock");

  a_ext_hold: assert property (
    src_q[1] == PISC_SRC_EXT && !ext_edge[1] |=> $stable(samp_q[1]))
    else $error("external source sample changed without a pulse");

  a_ext_load: assert property (
    src_q[1] == PISC_SRC_EXT && ext_edge[1] |=> samp_q[1] == $past(cap_data[1]))
    else $error("external pulse did not load the captured word");

  a_deb_restart: assert property (
    samp_q[0] != last_q[0] |=> cnt_q[0] == '0 && !evt_q[0])
    else $error("debounce count not restarted on input change");

  a_evt_value: assert property (
    evt_q[1] |-> cur_q[1] == $past(last_q[1]) && !$past(evt_q[1]))
    else $error("new data event without settled value");

  a_pair_tick: assert property (tick[0] |=> pre_q[0] == '0 ##1 !tick[0])
    else $error("shared debounce prescaler misbehaved");

endmodule : pisc_top

// ### test/pisc_far_end.sv
// Far-side model: one isolated input word with its own external clock
`timescale 1ns/100ps
module pisc_far_end
  import pisc_pkg::*;
(
  output logic ext_clk,
  output logic [PORT_W-1:0] data
);
  initial begin
    ext_clk = 1'b0;
    data = '0;
  end

  // One frame: one 40 ns pulse, then the clock stands still
  task automatic send(input logic [PORT_W-1:0] w);
    #13;
    data = ~w;
    #40;
    ext_clk = 1'b1;
    // Word shows only after the rising edge, so a rising-edge capture misses it
    #20;
    data = w;
    #20;
    ext_clk = 1'b0;
    #40;
    // Hold time over: stale line shows the inverse, never the old word
    data = ~w;
  endtask : send
endmodule : pisc_far_end

// ### test/tb_top.sv
// Self-checking bench for the port input sampling front end
`timescale 1ns/100ps
module tb_top;
  import pisc_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic cfg_wr = 1'b0;
  logic cfg_ext = 1'b0;
  logic rst_cmd = 1'b0;
  logic deb_wr = 1'b0;
  logic [1:0] cfg_port = 2'h0;
  logic [1:0] deb_port = 2'h0;
  logic [DEB_CODE_W-1:0] deb_code = 5'h00;
  logic [NUM_PORTS-1:0] en = 4'h0;
  logic [15:0] p0_word = 16'h0000;
  logic [15:0] far_data;
  logic far_clk;
  logic [NUM_PORTS-1:0] src_sel;
  logic err_pulse;
  logic [15:0] err_code;
  logic [NUM_PAIRS-1:0][DEB_CODE_W-1:0] deb_code_rd;
  logic [63:0] cur_val;
  logic [NUM_PORTS-1:0] new_data_event;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #12.5 clk = ~clk;

  pisc_far_end far (.ext_clk(far_clk), .data(far_data));

  pisc_top uut (
    .clk(clk), .resetn(resetn), .link_clk({2'b00, far_clk, 1'b0}),
    .in_data({32'h0, far_data, p0_word}), .cfg_wr(cfg_wr), .cfg_port(cfg_port),
    .cfg_ext(cfg_ext), .new_data_event_en(en), .rst_cmd(rst_cmd), .deb_wr(deb_wr),
    .deb_port(deb_port), .deb_code(deb_code), .src_sel(src_sel), .err_pulse(err_pulse),
    .err_code(err_code), .deb_code_rd(deb_code_rd), .cur_val(cur_val),
    .new_data_event(new_data_event)
  );

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Kind 0 source write, 1 debounce write, 2 reset command
  task automatic pulse(input int k, input logic [1:0] p, input logic v);
    @(posedge clk);
    cfg_port <= p;
    deb_port <= p;
    cfg_ext <= v;
    deb_code <= v ? DEB_CODE_MAX : 5'h00;
    cfg_wr <= (k == 0);
    deb_wr <= (k == 1);
    rst_cmd <= (k == 2);
    @(posedge clk);
    cfg_wr <= 1'b0;
    deb_wr <= 1'b0;
    rst_cmd <= 1'b0;
    @(negedge clk);
  endtask : pulse

  // Bounded wait; settle takes at most about 725 clocks at code 0
  task automatic wait_ev(input int p, input logic [15:0] w);
    int n;
    n = 0;
    while (new_data_event[p] !== 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    chk({n < 1000, cur_val[p*16 +: 16]}, {1'b1, w});
  endtask : wait_ev

  task automatic sc_config;
    chk({src_sel, err_code}, 20'h0);
    pulse(0, 2'h1, 1'b1);
    chk(src_sel, 4'h2);
    pulse(0, 2'h2, 1'b1);
    chk(src_sel, 4'h6);
    @(posedge clk) en <= 4'h2;
    pulse(0, 2'h1, 1'b0);
    chk({src_sel, err_pulse, err_code}, {4'h6, 1'b1, ERR_SETTINGS_CONFLICT});
    @(negedge clk);
    chk(err_pulse, 1'b0);
    pulse(1, 2'h3, 1'b1);
    chk(deb_code_rd, {DEB_CODE_MAX, 5'h00});
    // Port 2 has no event enabled, so going internal is allowed there
    pulse(0, 2'h2, 1'b0);
    chk({src_sel, err_pulse}, {4'h2, 1'b0});
    pulse(2, 2'h0, 1'b0);
    chk({src_sel, deb_code_rd}, 14'h0);
    @(posedge clk) en <= 4'h0;
  endtask : sc_config

  task automatic sc_sampling;
    pulse(0, 2'h1, 1'b1);
    @(posedge clk) p0_word <= 16'ha5c3;
    wait_ev(0, 16'ha5c3);
    far.send(16'h3c5a);
    wait_ev(1, 16'h3c5a);
    // Stale line after the pulse must never reach the port
    repeat (800) @(negedge clk);
    chk(cur_val, {32'h0, 32'h3c5aa5c3});
  endtask : sc_sampling

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    sc_config();
    sc_sampling();
    complete_run();
  end
endmodule : tb_top
